// >>> core/secreg_pkg.sv
// Constants and types for the security register command block
package secreg_pkg;

   localparam logic [7:0] OPC_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OPC_READ_STATUS    = 8'h05;
   localparam logic [7:0] OPC_SECREG_ERASE   = 8'h44;
   localparam logic [7:0] OPC_SECREG_PROGRAM = 8'h42;
   localparam logic [7:0] OPC_SECREG_READ    = 8'h48;
   localparam logic [7:0] OPC_RESET_ENABLE   = 8'h66;
   localparam logic [7:0] OPC_RESET          = 8'h99;

   localparam int unsigned NUM_SECREGS  = 4;
   localparam int unsigned SECREG_BYTES = 256;
   localparam logic [7:0]  SECREG_ERASED_BYTE = 8'hff;
   localparam logic [7:0]  ADDR_UPPER_BYTE    = 8'h00;

   // Frame byte positions; DATA_PHASE saturates the byte counter
   localparam logic [2:0] BYTE_OPCODE = 3'h0;
   localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
   localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
   localparam logic [2:0] BYTE_ADDR_LO = 3'h3;
   localparam logic [2:0] BYTE_FOURTH = 3'h4;
   localparam logic [2:0] DATA_PHASE = 3'h5;

   localparam int unsigned STATUS_BUSY_BIT  = 0;
   localparam int unsigned STATUS_LATCH_BIT = 1;
   localparam logic        LATCH_RESET = 1'b0;

   localparam int unsigned CLOCK_PERIOD_NS        = 5;
   localparam int unsigned SECREG_ERASE_TIME_US   = 1000;
   localparam int unsigned PAGE_WRITE_TIME_US     = 500;
   localparam int unsigned RESET_RECOVERY_TIME_US = 30;
   localparam int unsigned SECREG_ERASE_CYCLES =
      (SECREG_ERASE_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int unsigned PAGE_WRITE_CYCLES =
      (PAGE_WRITE_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int unsigned RESET_RECOVERY_CYCLES =
      (RESET_RECOVERY_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] addr_hi;
      logic [7:0] addr_mid;
      logic [7:0] addr_lo;
   } frame_hdr_t;

   typedef enum {OP_IDLE, OP_ERASE, OP_PROGRAM, OP_RESET} op_state_t;

endpackage

// >>> core/secreg_flash_core.sv
// Serial flash security register erase, program, read and software reset
`timescale 1ns/100ps
module secreg_flash_core
   import secreg_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES   = SECREG_ERASE_CYCLES,
   parameter int unsigned PROGRAM_CYCLES = PAGE_WRITE_CYCLES,
   parameter int unsigned RESET_CYCLES   = RESET_RECOVERY_CYCLES
)(
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   input  wire logic i_cs_n,
   input  wire logic i_sclk,
   input  wire logic i_si,
   output wire logic o_so,
   output wire logic o_so_oe_n,
   input  wire logic i_secreg_lock_bit,
   input  wire logic i_prog_paused,
   input  wire logic i_erase_paused,
   output wire logic o_write_latch_flag,
   output wire logic o_op_in_progress_flag,
   output wire logic o_reset_busy,
   output wire logic o_soft_reset
);

   logic [2:0]  cs_sync_q;
   logic [2:0]  sclk_sync_q;
   logic [1:0]  si_sync_q;
   logic [2:0]  bit_q;
   logic [2:0]  byte_q;
   logic [7:0]  shift_q;
   frame_hdr_t  hdr_q;
   logic [7:0]  offset_q;
   logic        ign_q;
   logic        out_en_q;
   logic [2:0]  out_bit_q;
   logic        so_q;
   logic        so_oe_n_q;
   logic        latch_q;
   logic        rst_armed_q;
   logic        soft_reset_q;
   op_state_t   op_q;
   logic [31:0] timer_q;
   logic [31:0] held_q;
   logic        sweep_on_q;
   logic [7:0]  sweep_q;
   logic [1:0]  sel_q;
   logic [SECREG_BYTES-1:0] mask_q;
   logic [7:0]  buf_q [SECREG_BYTES];
   logic [7:0]  mem_q [NUM_SECREGS*SECREG_BYTES];

   // Pins cross from the host's domain through two flops; the third only finds edges
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_sync_q   <= 3'h7;
         sclk_sync_q <= 3'h0;
         si_sync_q   <= 2'h0;
      end else begin
         cs_sync_q   <= {cs_sync_q[1:0], i_cs_n};
         sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
         si_sync_q   <= {si_sync_q[0], i_si};
      end
   end

   wire       cs_low    = !cs_sync_q[1];
   wire       cs_fall   = cs_sync_q[2] & !cs_sync_q[1];
   wire       cs_rise   = !cs_sync_q[2] & cs_sync_q[1];
   wire       sclk_rise = cs_low & !sclk_sync_q[2] & sclk_sync_q[1];
   wire       sclk_fall = cs_low & sclk_sync_q[2] & !sclk_sync_q[1];
   wire [7:0] rx_byte   = {shift_q[6:0], si_sync_q[1]};
   wire       byte_done = sclk_rise & (bit_q == 3'h7);
   wire       idle      = (op_q == OP_IDLE);
   wire       busy      = (op_q == OP_ERASE) | (op_q == OP_PROGRAM);
   wire       aligned   = (bit_q == 3'h0) & !ign_q;

   // Upper byte zero and middle byte naming one of four registers
   wire addr_ok = (hdr_q.addr_hi == ADDR_UPPER_BYTE) & (hdr_q.addr_mid[7:2] == 6'h0);

   wire [7:0] status_byte = {6'h0, latch_q, busy};
   wire [9:0] rd_addr     = {hdr_q.addr_mid[1:0], offset_q};
   wire       is_status   = (hdr_q.opcode == OPC_READ_STATUS);
   wire [7:0] tx_byte     = is_status ? status_byte : mem_q[rd_addr];

   // Status reads are served in every operation state except reset recovery, whose frames are ignored
   wire start_status = byte_done & (byte_q == BYTE_OPCODE)
                     & (rx_byte == OPC_READ_STATUS) & !ign_q;
   wire start_read   = byte_done & (byte_q == BYTE_FOURTH) & idle & !ign_q
                     & (hdr_q.opcode == OPC_SECREG_READ) & addr_ok;
   wire data_byte    = byte_done & (byte_q >= BYTE_FOURTH) & idle & !ign_q
                     & (hdr_q.opcode == OPC_SECREG_PROGRAM);

   // Whole bytes only; a frame cut inside a byte does nothing
   wire erase_go = cs_rise & aligned & idle & (hdr_q.opcode == OPC_SECREG_ERASE)
                 & (byte_q == BYTE_FOURTH) & addr_ok & latch_q
                 & !i_secreg_lock_bit & !i_prog_paused & !i_erase_paused;
   wire prog_go  = cs_rise & aligned & idle & (hdr_q.opcode == OPC_SECREG_PROGRAM)
                 & (byte_q == DATA_PHASE) & addr_ok & latch_q
                 & !i_secreg_lock_bit & !i_prog_paused;
   wire one_byte = cs_rise & aligned & (byte_q == BYTE_ADDR_HI);
   wire write_enable_cmd_go  = one_byte & idle & (hdr_q.opcode == OPC_WRITE_ENABLE);
   wire rst_go   = one_byte & rst_armed_q & (hdr_q.opcode == OPC_RESET);

   // Frame capture and serial output
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bit_q     <= 3'h0;
         byte_q    <= BYTE_OPCODE;
         shift_q   <= 8'h00;
         hdr_q     <= '0;
         offset_q  <= 8'h00;
         ign_q     <= 1'b0;
         out_en_q  <= 1'b0;
         out_bit_q <= 3'h0;
         so_q      <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else if (cs_fall) begin
         bit_q     <= 3'h0;
         byte_q    <= BYTE_OPCODE;
         hdr_q     <= '0;
         out_en_q  <= 1'b0;
         out_bit_q <= 3'h0;
         ign_q     <= (op_q == OP_RESET);
      end else if (!cs_low) begin
         out_en_q  <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else if (sclk_rise) begin
         bit_q   <= bit_q + 3'h1;
         shift_q <= rx_byte;
         if (bit_q == 3'h7) begin
            if (byte_q != DATA_PHASE) begin
               byte_q <= byte_q + 3'h1;
            end
            case (byte_q)
               BYTE_OPCODE:   hdr_q.opcode   <= rx_byte;
               BYTE_ADDR_HI:  hdr_q.addr_hi  <= rx_byte;
               BYTE_ADDR_MID: hdr_q.addr_mid <= rx_byte;
               BYTE_ADDR_LO: begin
                  hdr_q.addr_lo <= rx_byte;
                  offset_q      <= rx_byte;
               end
               default: begin
                  if (data_byte) begin
                     offset_q <= offset_q + 8'h01;
                  end
               end
            endcase
            if (start_status | start_read) begin
               out_en_q <= 1'b1;
            end
         end
      end else if (sclk_fall & out_en_q) begin
         so_q      <= tx_byte[~out_bit_q];
         so_oe_n_q <= 1'b0;
         out_bit_q <= out_bit_q + 3'h1;
         if ((out_bit_q == 3'h7) & !is_status) begin
            offset_q <= offset_q + 8'h01;
         end
      end
   end

   // Page buffer mask; left alone while a write is sweeping into the array
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_q <= '0;
      end else if (cs_fall & idle) begin
         mask_q <= '0;
      end else if (data_byte) begin
         mask_q[offset_q] <= 1'b1;
      end
   end

   // Array is nonvolatile, so it has no reset; program can only clear bits
   wire [9:0] sweep_addr = {sel_q, sweep_q};
   always_ff @(posedge i_clock) begin
      if (data_byte) begin
         buf_q[offset_q] <= rx_byte;
      end
      if (sweep_on_q & (op_q == OP_ERASE)) begin
         mem_q[sweep_addr] <= SECREG_ERASED_BYTE;
      end else if (sweep_on_q & (op_q == OP_PROGRAM) & mask_q[sweep_q]) begin
         mem_q[sweep_addr] <= mem_q[sweep_addr] & buf_q[sweep_q];
      end
   end

   // Self-timed operations and reset recovery
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         op_q         <= OP_IDLE;
         timer_q      <= 32'h0;
         sweep_on_q   <= 1'b0;
         sweep_q      <= 8'h00;
         sel_q        <= 2'h0;
         latch_q      <= LATCH_RESET;
         rst_armed_q  <= 1'b0;
         soft_reset_q <= 1'b0;
      end else begin
         soft_reset_q <= rst_go;
         if (cs_rise & !ign_q) begin
            rst_armed_q <= one_byte & (hdr_q.opcode == OPC_RESET_ENABLE);
         end
         if (erase_go | prog_go | rst_go) begin
            latch_q <= 1'b0;
         end else if (write_enable_cmd_go) begin
            latch_q <= 1'b1;
         end
         if (sweep_on_q) begin
            sweep_q <= sweep_q + 8'h01;
            if (sweep_q == 8'hff) begin
               sweep_on_q <= 1'b0;
            end
         end
         case (op_q)
            OP_IDLE: begin
               if (rst_go) begin
                  op_q    <= OP_RESET;
                  timer_q <= RESET_CYCLES - 1;
               end else if (erase_go | prog_go) begin
                  op_q       <= erase_go ? OP_ERASE : OP_PROGRAM;
                  timer_q    <= (erase_go ? ERASE_CYCLES : PROGRAM_CYCLES) - 1;
                  sweep_on_q <= 1'b1;
                  sweep_q    <= 8'h00;
                  sel_q      <= hdr_q.addr_mid[1:0];
               end
            end
            OP_ERASE, OP_PROGRAM: begin
               if (rst_go) begin
                  op_q       <= OP_RESET;
                  timer_q    <= RESET_CYCLES - 1;
                  sweep_on_q <= 1'b0;
               end else if (timer_q == 32'h0) begin
                  op_q <= OP_IDLE;
               end else begin
                  timer_q <= timer_q - 32'h1;
               end
            end
            OP_RESET: begin
               if (timer_q == 32'h0) begin
                  op_q <= OP_IDLE;
               end else begin
                  timer_q <= timer_q - 32'h1;
               end
            end
            default: op_q <= OP_IDLE;
         endcase
      end
   end

   // Counts cycles of the timed operation apart from the down-counter that it checks
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         held_q <= 32'h0;
      end else if (idle | (rst_go & busy)) begin
         held_q <= 32'h0;
      end else begin
         held_q <= held_q + 32'h1;
      end
   end

   assign o_so                  = so_q;
   assign o_so_oe_n             = so_oe_n_q;
   assign o_write_latch_flag    = latch_q;
   assign o_op_in_progress_flag = busy;
   assign o_reset_busy          = (op_q == OP_RESET);
   assign o_soft_reset          = soft_reset_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   a_erase_starts: assert property (erase_go |=> op_q == OP_ERASE && o_op_in_progress_flag)
      else $error("erase did not start on select rise");
   a_prog_starts: assert property (prog_go |=> op_q == OP_PROGRAM ##1 o_op_in_progress_flag)
      else $error("program did not start on select rise");
   a_lock_blocks: assert property (i_secreg_lock_bit |-> !erase_go && !prog_go)
      else $error("locked registers accepted a write");
   a_paused_blocks: assert property (i_prog_paused |-> !erase_go && !prog_go)
      else $error("write accepted during paused program");
   a_latch_dropped: assert property ($rose(o_op_in_progress_flag) |-> !o_write_latch_flag)
      else $error("write latch still set in cycle");
   a_busy_ends: assert property (busy && timer_q == 32'h0 && !rst_go |=> !o_op_in_progress_flag)
      else $error("in-progress flag stuck after cycle");
   a_short_drop: assert property (cs_rise && byte_q == BYTE_OPCODE |-> !erase_go && !prog_go)
      else $error("frame without full opcode executed");
   a_reset_hold: assert property (rst_go |=> (o_reset_busy && !latch_q) [*8])
      else $error("reset recovery ended early");
   a_read_wrap: assert property (sclk_fall && out_en_q && out_bit_q == 3'h7 && !is_status
      && offset_q == 8'hff |=> offset_q == 8'h00 && $stable(hdr_q.addr_mid))
      else $error("read offset did not wrap in register");
   a_status_busy: assert property (start_status && busy |=> out_en_q)
      else $error("status read refused while busy");

   // Cycle lengths, latch handling and reset behaviour
   a_erase_len: assert property (op_q == OP_ERASE && timer_q == 32'h0
      |-> held_q == ERASE_CYCLES - 1) else $error("erase cycle length wrong");
   a_prog_len: assert property (op_q == OP_PROGRAM && timer_q == 32'h0
      |-> held_q == PROGRAM_CYCLES - 1) else $error("program cycle length wrong");
   a_recovery_len: assert property (o_reset_busy && timer_q == 32'h0
      |-> held_q == RESET_CYCLES - 1) else $error("reset recovery length wrong");
   a_sweep_done: assert property (busy && timer_q == 32'h0 |=> !sweep_on_q)
      else $error("array sweep outlived the cycle");
   a_latch_set: assert property (write_enable_cmd_go |=> o_write_latch_flag)
      else $error("write enable did not set latch");
   a_latch_needed: assert property (!latch_q |-> !erase_go && !prog_go)
      else $error("write accepted without latch");
   a_erase_paused: assert property (i_erase_paused |-> !erase_go)
      else $error("erase accepted during paused erase");
   a_recovery_latch: assert property (o_reset_busy |=> !o_write_latch_flag)
      else $error("latch set during reset recovery");
   a_reset_aborts: assert property (rst_go |=> o_soft_reset && !o_write_latch_flag
      && !o_op_in_progress_flag) else $error("reset did not abort work");
   a_soft_pulse: assert property (o_soft_reset |=> !o_soft_reset)
      else $error("reset pulse longer than one cycle");
   a_oe_idle: assert property (!cs_low |=> o_so_oe_n)
      else $error("output driven while deselected");
   a_so_steady: assert property (!(sclk_fall && out_en_q) |=> $stable(o_so))
      else $error("output changed off a falling edge");
   a_ign_frames: assert property (ign_q && cs_rise
      |=> $stable(o_write_latch_flag) && !o_soft_reset) else $error("frame in recovery acted");
   a_status_bits: assert property (start_status |=> is_status && out_en_q)
      else $error("status read not started");

endmodule

// >>> test/link_host.sv
// Host serial controller model that frames commands for the flash
`timescale 1ns/100ps
module link_host (
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_si,
   input  wire logic i_so,
   input  wire logic i_so_oe_n
);
   logic [7:0] tx_bytes [0:259];
   logic [7:0] rx_bytes [0:259];
   logic       oe_seen;

   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
      oe_seen = 1'b0;
   end

   // Whole bytes only; so is sampled just before each rising edge
   task automatic frame(input int n);
      o_cs_n = 1'b0;
      oe_seen = 1'b0;
      #30;
      for (int b = 0; b < n; b++) begin
         for (int k = 7; k >= 0; k--) begin
            o_si = tx_bytes[b][k];
            #24;
            rx_bytes[b][k] = (i_so_oe_n === 1'b0) ? i_so : ~i_so;
            if (i_so_oe_n === 1'b0) begin
               oe_seen = 1'b1;
            end
            o_sclk = 1'b1;
            #24;
            o_sclk = 1'b0;
         end
      end
      #30;
      o_cs_n = 1'b1;
      // Deselected line must not keep showing the last bit
      o_si = ~o_si;
      #60;
   endtask
endmodule

// >>> test/tb_secreg_flash_core.sv
// Self-checking bench for the security register command block
`timescale 1ns/100ps
module tb_secreg_flash_core;
   import secreg_pkg::*;
   logic i_clock, i_reset_n, cs_n, sclk, si, so, oe_n;
   logic lock, p_pause, e_pause, wl, busy, rbusy, srst;
   int   fail_count, n_tests, pulses;
   // Refusal table: bit3 skips enable, bits 2..0 drive lock, program and erase pause
   logic [3:0] cond [0:7] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h8, 4'h0};
   logic [7:0] opc  [0:7] = '{8'h44, 8'h42, 8'h44, 8'h42, 8'h44, 8'h42, 8'h42, 8'h44};
   logic [7:0] mids [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h04};
   logic       acc  [0:7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

   secreg_flash_core #(.ERASE_CYCLES(300), .PROGRAM_CYCLES(300), .RESET_CYCLES(200))
   secreg_flash_core_inst (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_si(si), .o_so(so), .o_so_oe_n(oe_n), .i_secreg_lock_bit(lock),
      .i_prog_paused(p_pause), .i_erase_paused(e_pause), .o_write_latch_flag(wl),
      .o_op_in_progress_flag(busy), .o_reset_busy(rbusy), .o_soft_reset(srst));

   link_host link_host_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so),
      .i_so_oe_n(oe_n));

   initial i_clock = 1'b0;
   always #2.5 i_clock = ~i_clock;

   always @(posedge i_clock) begin
      if (srst === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check_flag(input string what, input logic exp, input logic seen);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send(input logic [7:0] op, input logic [7:0] mid, input logic [7:0] lo,
                       input int n);
      @(posedge i_clock);
      #1;
      link_host_inst.tx_bytes[0] = op;
      link_host_inst.tx_bytes[1] = ADDR_UPPER_BYTE;
      link_host_inst.tx_bytes[2] = mid;
      link_host_inst.tx_bytes[3] = lo;
      link_host_inst.frame(n);
   endtask

   // Bounded wait so a stuck busy flag fails instead of hanging
   task automatic wait_idle();
      int k;
      k = 0;
      while ((busy !== 1'b0 || rbusy !== 1'b0) && k < 2000) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      check_flag("idle reached", 1'b1, k < 2000);
   endtask

   initial begin
      #400000;
      fail_count++;
      conclude();
   end

   initial begin
      i_reset_n = 1'b0;
      {lock, p_pause, e_pause} = 3'h0;
      fail_count = 0;
      n_tests = 0;
      pulses = 0;
      repeat (2) @(posedge i_clock);
      #1 i_reset_n = 1'b1;
      repeat (4) @(posedge i_clock);
      // Contents are unknown until erased, so every register is erased first
      for (int r = 0; r < 4; r++) begin
         send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
         check_flag("latch set", 1'b1, wl);
         send(OPC_SECREG_ERASE, 8'(r), 8'h00, 4);
         check_flag("erase busy", 1'b1, busy);
         check_flag("latch in erase", 1'b0, wl);
         send(OPC_READ_STATUS, 8'h00, 8'h00, 2);
         check_byte("status in erase", 8'h01, link_host_inst.rx_bytes[1]);
         wait_idle();
      end
      for (int i = 0; i < 256; i++) begin
         link_host_inst.tx_bytes[4 + i] = 8'(i) ^ 8'h5a;
      end
      send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
      send(OPC_SECREG_PROGRAM, 8'h01, 8'h00, 260);
      check_flag("program busy", 1'b1, busy);
      wait_idle();
      link_host_inst.tx_bytes[4] = 8'h3c;
      send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
      send(OPC_SECREG_PROGRAM, 8'h02, 8'h7f, 5);
      wait_idle();
      send(OPC_SECREG_READ, 8'h01, 8'hff, 8);
      check_byte("read top", 8'ha5, link_host_inst.rx_bytes[5]);
      check_byte("read wrap", 8'h5a, link_host_inst.rx_bytes[6]);
      check_byte("read next", 8'h5b, link_host_inst.rx_bytes[7]);
      check_flag("output on", 1'b1, link_host_inst.oe_seen);
      send(OPC_SECREG_READ, 8'h02, 8'h7f, 7);
      check_byte("read single", 8'h3c, link_host_inst.rx_bytes[5]);
      check_byte("read erased", SECREG_ERASED_BYTE, link_host_inst.rx_bytes[6]);
      for (int c = 0; c < 8; c++) begin
         if (cond[c][3] !== 1'b1) begin
            send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
         end
         @(posedge i_clock);
         #1 {lock, p_pause, e_pause} = cond[c][2:0];
         // Erase frames must be exactly four bytes, or the refusal would not come from cond
         send(opc[c], mids[c], 8'h00, (opc[c] == OPC_SECREG_ERASE) ? 4 : 5);
         check_flag("refusal table", acc[c], busy);
         wait_idle();
         @(posedge i_clock);
         #1 {lock, p_pause, e_pause} = 3'h0;
      end
      send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
      send(OPC_SECREG_ERASE, 8'h00, 8'h00, 4);
      send(OPC_RESET_ENABLE, 8'h00, 8'h00, 1);
      check_flag("erase before reset", 1'b1, busy);
      send(OPC_RESET, 8'h00, 8'h00, 1);
      check_flag("recovery busy", 1'b1, rbusy);
      check_flag("erase aborted", 1'b0, busy);
      check_flag("latch cleared", 1'b0, wl);
      check_byte("reset pulses", 8'h01, 8'(pulses));
      send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
      check_flag("enable in recovery", 1'b0, wl);
      wait_idle();
      send(OPC_WRITE_ENABLE, 8'h00, 8'h00, 1);
      check_flag("enable after recovery", 1'b1, wl);
      conclude();
   end
endmodule
